// file: inc/mfr_pkg.sv
// Shared constants and types for the multi-frame receive buffer.
// Assumes a 32-bit APB master and a byte-wide receive decoder on the same clock.
`default_nettype none

package mfr_pkg;

    // ------------------------------------------------------------------
    // Buffer geometry
    // ------------------------------------------------------------------
    localparam int unsigned SUB_BYTES      = 32;
    localparam int unsigned MAX_FRAMES     = 8;
    localparam int unsigned MAX_PAYLOAD    = 28;
    localparam int unsigned BUF_WORDS      = 64;
    localparam int unsigned WORD_IDX_W     = 6;
    localparam int unsigned SUB_IDX_W      = 3;
    localparam int unsigned COUNT_W        = 4;

    localparam logic [7:0]         PAYLOAD_LIMIT   = 8'h1C;
    localparam logic [7:0]         BYTE_CNT_MAX    = 8'hFF;
    localparam logic [COUNT_W-1:0] FRAMES_LIMIT    = 4'h8;
    localparam logic [2:0]         STATUS_WORD_POS = 3'h7;
    localparam logic [7:0]         FIRST_BYTE_POS  = 8'h00;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] STATUS_OFS    = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFS  = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFS  = 12'h00C;
    localparam logic [11:0] BUF_BASE_OFS  = 12'h100;
    localparam logic [11:0] BUF_END_OFS   = 12'h1FC;

    // Control register fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_START_BIT  = 1;
    localparam int unsigned CTRL_IDLE_BIT   = 2;

    // Interrupt bits
    localparam int unsigned IRQ_W           = 3;
    localparam int unsigned IRQ_RX_DONE_BIT = 0;
    localparam int unsigned IRQ_CYCLE_BIT   = 1;
    localparam int unsigned IRQ_LEN_BIT     = 2;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_RECEIVE = 2'b01,
        ST_STATUS  = 2'b10,
        ST_AWAIT   = 2'b11
    } rx_state_t;

    typedef struct packed {
        logic integrity;
        logic protocol;
        logic collision;
    } rx_err_t;

    typedef struct packed {
        logic [18:0] reserved;
        logic        length_error_flag;
        logic        combined_error_flag;
        logic        collision;
        logic        protocol;
        logic        integrity;
        logic [7:0]  byte_count;
    } status_word_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rx_byte_t;

endpackage : mfr_pkg

`default_nettype wire

// file: hdl/status_word_pack.sv
// Builds the status word that closes each sub-buffer.
// Assumes inputs are stable in the cycle the word is stored.
`timescale 1ns/1ps
`default_nettype none

module status_word_pack (
    input  wire logic [7:0]      byte_count_i,
    input  wire mfr_pkg::rx_err_t err_i,
    input  wire logic            length_error_i,
    output mfr_pkg::status_word_t word_o
);

    // ------------------------------------------------------------------
    // Field packing
    // ------------------------------------------------------------------
    assign word_o.reserved            = '0;
    assign word_o.length_error_flag   = length_error_i;
    assign word_o.combined_error_flag = err_i.integrity | err_i.protocol
                                        | err_i.collision;
    assign word_o.collision           = err_i.collision;
    assign word_o.protocol            = err_i.protocol;
    assign word_o.integrity           = err_i.integrity;
    assign word_o.byte_count          = byte_count_i;

endmodule : status_word_pack

`default_nettype wire

// file: hdl/multi_frame_rx_buffer.sv
// Multi-frame receive buffer with APB register access.
// Assumes the receive decoder runs on clk_i and delivers one frame per start/end pair.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module multi_frame_rx_buffer (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // Receive decoder
    input  wire logic             rx_start_i,
    input  wire mfr_pkg::rx_byte_t rx_byte_i,
    input  wire logic             rx_end_i,
    input  wire mfr_pkg::rx_err_t rx_err_i,
    // Transceive control
    output logic                  rx_enable_o,
    output logic                  await_send_o,
    output logic                  rx_complete_o,
    output logic                  irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mfr_pkg::rx_state_t        state;
    mfr_pkg::rx_state_t        next_state;
    logic [31:0]               mem [mfr_pkg::BUF_WORDS];
    logic                      multi_frame_receive;
    logic [mfr_pkg::COUNT_W-1:0] frames_received_count;
    logic [7:0]                byte_idx;
    logic [7:0]                len_byte;
    logic                      in_frame;
    mfr_pkg::rx_err_t          err_q;
    logic                      short_q;
    logic [mfr_pkg::IRQ_W-1:0] irq_status;
    logic [mfr_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0]               rdata_q;
    logic                      err_q_bus;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire setup_phase  = psel & ~penable;
    wire access_wr    = psel & penable & pready & pwrite;
    wire sel_ctrl     = (paddr == mfr_pkg::CTRL_OFS);
    wire sel_status   = (paddr == mfr_pkg::STATUS_OFS);
    wire sel_irq_stat = (paddr == mfr_pkg::IRQ_STAT_OFS);
    wire sel_irq_mask = (paddr == mfr_pkg::IRQ_MASK_OFS);
    wire sel_buf      = (paddr >= mfr_pkg::BUF_BASE_OFS) && (paddr <= mfr_pkg::BUF_END_OFS)
                        && (paddr[1:0] == 2'b00);
    wire sel_any      = sel_ctrl | sel_status | sel_irq_stat | sel_irq_mask | sel_buf;
    wire [mfr_pkg::WORD_IDX_W-1:0] buf_rd_idx = paddr[mfr_pkg::WORD_IDX_W+1:2];

    wire wr_ctrl      = access_wr & sel_ctrl;
    wire start_cmd    = wr_ctrl & pwdata[mfr_pkg::CTRL_START_BIT];
    wire idle_cmd     = wr_ctrl & pwdata[mfr_pkg::CTRL_IDLE_BIT];
    wire clear_irq    = access_wr & sel_irq_stat;
    wire wr_mask      = access_wr & sel_irq_mask;

    wire [31:0] status_rd = {26'h0, state, frames_received_count};
    wire [31:0] ctrl_rd   = {31'h0, multi_frame_receive};

    wire [31:0] rd_mux =
        sel_ctrl     ? ctrl_rd :
        sel_status   ? status_rd :
        sel_irq_stat ? {29'h0, irq_status} :
        sel_irq_mask ? {29'h0, irq_mask} :
        sel_buf      ? mem[buf_rd_idx] :
                       mfr_pkg::ZERO_WORD;

    assign pready  = 1'b1;
    assign prdata  = rdata_q;
    assign pslverr = psel & penable & err_q_bus;

    // Read data and error captured in the setup cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q   <= mfr_pkg::ZERO_WORD;
            err_q_bus <= 1'b0;
        end else if (setup_phase) begin
            rdata_q   <= pwrite ? mfr_pkg::ZERO_WORD : rd_mux;
            err_q_bus <= ~sel_any;
        end
    end

    // ------------------------------------------------------------------
    // Control and interrupt mask registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            multi_frame_receive <= 1'b0;
            irq_mask            <= '0;
        end else begin
            if (wr_ctrl) begin
                multi_frame_receive <= pwdata[mfr_pkg::CTRL_ENABLE_BIT];
            end
            if (wr_mask) begin
                irq_mask <= pwdata[mfr_pkg::IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame byte tracking
    // ------------------------------------------------------------------
    wire receiving    = (state == mfr_pkg::ST_RECEIVE);
    wire byte_take    = receiving & in_frame & rx_byte_i.valid;
    wire first_byte   = (byte_idx == mfr_pkg::FIRST_BYTE_POS);
    wire [7:0] len_now = first_byte ? rx_byte_i.data : len_byte;
    wire len_over     = (len_now > mfr_pkg::PAYLOAD_LIMIT);
    wire len_over_q   = (len_byte > mfr_pkg::PAYLOAD_LIMIT);
    // Oversize frames and bytes past the payload area are dropped
    wire store_byte   = byte_take & ~len_over
                        & (byte_idx < mfr_pkg::PAYLOAD_LIMIT);
    wire frame_end    = receiving & in_frame & rx_end_i;
    wire short_now    = (byte_idx < len_byte);
    wire length_error = len_over_q | short_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            in_frame <= 1'b0;
            byte_idx <= '0;
            len_byte <= '0;
            err_q    <= '0;
            short_q  <= 1'b0;
        end else if (receiving && rx_start_i) begin
            in_frame <= 1'b1;
            byte_idx <= '0;
            len_byte <= '0;
        end else if (byte_take) begin
            if (first_byte) begin
                len_byte <= rx_byte_i.data;
            end
            if (byte_idx != mfr_pkg::BYTE_CNT_MAX) begin
                byte_idx <= byte_idx + 8'h01;
            end
        end else if (frame_end) begin
            in_frame <= 1'b0;
            err_q    <= rx_err_i;
            short_q  <= short_now;
        end else if (state == mfr_pkg::ST_IDLE) begin
            in_frame <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sub-buffer storage
    // ------------------------------------------------------------------
    mfr_pkg::status_word_t status_word;
    mfr_pkg::rx_err_t      err_report;

    // A short frame also shows as a protocol error
    assign err_report.integrity = err_q.integrity;
    assign err_report.protocol  = err_q.protocol | short_q;
    assign err_report.collision = err_q.collision;

    status_word_pack u_pack (
        .byte_count_i   (byte_idx),
        .err_i          (err_report),
        .length_error_i (length_error),
        .word_o         (status_word)
    );

    // Base taken from the count before it is incremented
    wire [mfr_pkg::SUB_IDX_W-1:0] sub_idx = frames_received_count[mfr_pkg::SUB_IDX_W-1:0];
    wire [mfr_pkg::WORD_IDX_W-1:0] data_word_idx = {sub_idx, byte_idx[4:2]};
    wire [mfr_pkg::WORD_IDX_W-1:0] stat_word_idx = {sub_idx, mfr_pkg::STATUS_WORD_POS};
    wire [1:0]                     lane          = byte_idx[1:0];

    // Gap bytes are never written
    always_ff @(posedge clk_i) begin
        if (store_byte) begin
            mem[data_word_idx][{lane, 3'b000} +: 8] <= rx_byte_i.data;
        end
        if (state == mfr_pkg::ST_STATUS) begin
            mem[stat_word_idx] <= status_word;
        end
    end

    // ------------------------------------------------------------------
    // Reception sequence
    // ------------------------------------------------------------------
    wire [mfr_pkg::COUNT_W-1:0] count_inc = frames_received_count + 4'h1;
    wire                        cycle_full = (count_inc == mfr_pkg::FRAMES_LIMIT);
    wire                        status_done = (state == mfr_pkg::ST_STATUS);
    wire                        go_await   = status_done & (~multi_frame_receive | cycle_full);

    always_comb begin
        next_state = state;
        case (state)
            mfr_pkg::ST_IDLE: begin
                if (start_cmd) begin
                    next_state = mfr_pkg::ST_RECEIVE;
                end
            end
            mfr_pkg::ST_RECEIVE: begin
                if (frame_end) begin
                    next_state = mfr_pkg::ST_STATUS;
                end
            end
            mfr_pkg::ST_STATUS: begin
                // Re-arm while enabled and room remains
                if (go_await) begin
                    next_state = mfr_pkg::ST_AWAIT;
                end else begin
                    next_state = mfr_pkg::ST_RECEIVE;
                end
            end
            mfr_pkg::ST_AWAIT: begin
                if (start_cmd) begin
                    next_state = mfr_pkg::ST_RECEIVE;
                end
            end
            default: begin
                next_state = mfr_pkg::ST_IDLE;
            end
        endcase
        if (idle_cmd) begin
            next_state = mfr_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state                 <= mfr_pkg::ST_IDLE;
            frames_received_count <= '0;
        end else begin
            state <= next_state;
            if (start_cmd && !idle_cmd && (state != mfr_pkg::ST_RECEIVE)
                && (state != mfr_pkg::ST_STATUS)) begin
                frames_received_count <= '0;
            end else if (status_done) begin
                frames_received_count <= count_inc;
            end
        end
    end

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    wire [mfr_pkg::IRQ_W-1:0] irq_set;
    assign irq_set[mfr_pkg::IRQ_RX_DONE_BIT] = status_done;
    assign irq_set[mfr_pkg::IRQ_CYCLE_BIT]   = go_await;
    assign irq_set[mfr_pkg::IRQ_LEN_BIT]     = status_done & length_error;

    // Set wins over a simultaneous clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~(clear_irq ? pwdata[mfr_pkg::IRQ_W-1:0] : '0)) | irq_set;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_enable_o   <= 1'b0;
            await_send_o  <= 1'b0;
            rx_complete_o <= 1'b0;
            irq_o         <= 1'b0;
        end else begin
            rx_enable_o   <= (next_state == mfr_pkg::ST_RECEIVE);
            await_send_o  <= (next_state == mfr_pkg::ST_AWAIT);
            rx_complete_o <= status_done;
            irq_o         <= |(((irq_status & ~(clear_irq ? pwdata[mfr_pkg::IRQ_W-1:0] : '0))
                               | irq_set) & irq_mask);
        end
    end

endmodule : multi_frame_rx_buffer

`default_nettype wire

// file: verification/mfr_checker.sv
// Port-level checks for the multi-frame receive buffer.
// Assumes it is bound to multi_frame_rx_buffer, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module mfr_checker (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        rx_end_i,
    input wire logic        rx_enable_o,
    input wire logic        await_send_o,
    input wire logic        rx_complete_o,
    input wire logic        irq_o
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic acc     = psel && penable;
    wire logic rd_acc  = acc && !pwrite;
    wire logic wr_ctl  = acc && pwrite && (paddr == mfr_pkg::CTRL_OFS);
    wire logic stat_rd = rd_acc && (paddr[11:8] == 4'h1) && (paddr[4:2] == 3'h7);
    wire logic mapped  = (paddr inside {mfr_pkg::CTRL_OFS, mfr_pkg::STATUS_OFS, mfr_pkg::IRQ_STAT_OFS,
                          mfr_pkg::IRQ_MASK_OFS}) || ((paddr[11:8] == 4'h1) && (paddr[1:0] == 2'h0));

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_frame_done: assert property (rx_end_i && rx_enable_o |-> ##1 !rx_complete_o ##1 rx_complete_o)
        else $error("frame end not followed by complete pulse");
    chk_done_pulse: assert property (rx_complete_o |=> !rx_complete_o)
        else $error("complete pulse longer than one cycle");
    chk_rx_rearm: assert property (rx_end_i && rx_enable_o |-> ##1 !rx_enable_o
        ##1 (rx_enable_o || await_send_o))
        else $error("receiver not re-armed after frame");
    chk_await_entry: assert property ($rose(await_send_o) |-> rx_complete_o)
        else $error("await state entered without frame end");
    chk_start_arms: assert property (wr_ctl && pwdata[mfr_pkg::CTRL_START_BIT]
        && !pwdata[mfr_pkg::CTRL_IDLE_BIT] |=> rx_enable_o && !await_send_o)
        else $error("start did not arm receiver");
    chk_idle_stops: assert property (wr_ctl && pwdata[mfr_pkg::CTRL_IDLE_BIT]
        |=> !rx_enable_o && !await_send_o)
        else $error("idle did not stop reception");
    chk_slverr_map: assert property (acc |-> (pslverr == !mapped) && pready)
        else $error("slave error does not match address map");
    chk_status_reserved: assert property (stat_rd |-> prdata[31:13] == 19'h0)
        else $error("reserved status bits not zero");
    chk_combined_error: assert property (stat_rd |-> prdata[11] == (|prdata[10:8]))
        else $error("combined error not OR of flags");
    chk_count_limit: assert property (rd_acc && (paddr == mfr_pkg::STATUS_OFS) |-> prdata[3:0] <= 4'h8)
        else $error("frame count above eight");
    chk_state_excl: assert property (!(rx_enable_o && await_send_o))
        else $error("receive and await both active");
    chk_mask_quiet: assert property (acc && pwrite && (paddr == mfr_pkg::IRQ_MASK_OFS) && (pwdata[2:0] == 3'h0)
        |-> ##2 !irq_o)
        else $error("interrupt high while fully masked");

    cover property (rx_complete_o && await_send_o);
    cover property (acc && pslverr);
    cover property ($fell(irq_o));
endmodule : mfr_checker

bind multi_frame_rx_buffer mfr_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rx_end_i(rx_end_i), .rx_enable_o(rx_enable_o), .await_send_o(await_send_o),
    .rx_complete_o(rx_complete_o), .irq_o(irq_o));

`default_nettype wire

// file: verification/card_model.sv
// Card side: answers one frame per call on the decoder interface.
// Assumes the same clock as the buffer; waits for the receiver to be armed.
`timescale 1ns/1ps
`default_nettype none

module card_model (
    input  wire logic         clk_i,
    input  wire logic         rx_enable_i,
    output logic              rx_start_o,
    output mfr_pkg::rx_byte_t rx_byte_o,
    output logic              rx_end_o,
    output mfr_pkg::rx_err_t  rx_err_o
);
    initial begin
        rx_start_o = 1'b0;
        rx_byte_o  = '0;
        rx_end_o   = 1'b0;
        rx_err_o   = '0;
    end

    // Byte 0 is the length byte, then a pattern tied to the frame number
    task automatic send_frame(input int k, input logic [7:0] len, input int n, input mfr_pkg::rx_err_t err,
                              input int gap);
        int t;
        t = 0;
        do begin
            @(negedge clk_i);
            t++;
        end while (rx_enable_i !== 1'b1 && t < 100);
        @(posedge clk_i);
        rx_start_o <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_start_o      <= 1'b0;
            rx_byte_o.valid <= 1'b1;
            rx_byte_o.data  <= (i == 0) ? len : 8'(k * 32 + i) ^ 8'hA5;
            repeat (gap) begin
                @(posedge clk_i);
                rx_byte_o.valid <= 1'b0;
                rx_byte_o.data  <= ~rx_byte_o.data;
            end
        end
        @(posedge clk_i);
        rx_byte_o.valid <= 1'b0;
        rx_byte_o.data  <= ~rx_byte_o.data;
        rx_end_o        <= 1'b1;
        rx_err_o        <= err;
        @(posedge clk_i);
        rx_end_o        <= 1'b0;
        rx_err_o        <= ~err;
        rx_byte_o.data  <= ~rx_byte_o.data;
    endtask : send_frame
endmodule : card_model

`default_nettype wire

// file: verification/multi_frame_rx_buffer_test.sv
// Self-checking bench: APB master, card model, read-result scoreboard.
// Assumes mfr_pkg and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none

module multi_frame_rx_buffer_test;
    logic              clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata;
    logic              rx_start_i, rx_end_i, rx_enable_o, await_send_o, rx_complete_o, irq_o;
    mfr_pkg::rx_byte_t rx_byte_i;
    mfr_pkg::rx_err_t  rx_err_i;
    int                error_cnt, total_checks, cycle_cnt;
    integer            seed;
    logic [31:0]       exp_q[$], msk_q[$];
    logic [7:0]        f_len[8];
    int                f_n[8];
    mfr_pkg::rx_err_t  f_err[8];

    multi_frame_rx_buffer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rx_start_i(rx_start_i), .rx_byte_i(rx_byte_i), .rx_end_i(rx_end_i), .rx_err_i(rx_err_i),
        .rx_enable_o(rx_enable_o), .await_send_o(await_send_o), .rx_complete_o(rx_complete_o), .irq_o(irq_o));
    card_model cards (.clk_i(clk_i), .rx_enable_i(rx_enable_o), .rx_start_o(rx_start_i), .rx_byte_o(rx_byte_i),
        .rx_end_o(rx_end_i), .rx_err_o(rx_err_i));

    // ------------------------------------------------------------------
    // Clock, timeout, scoreboard
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    always @(posedge clk_i) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            error_cnt++;
            report_and_stop();
        end
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
            check("prdata", prdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic apb_read(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb_xfer(1'b0, a, 32'h0000_0000);
    endtask : apb_read

    task automatic wait_await();
        for (int t = 0; t < 200 && await_send_o !== 1'b1; t++) @(posedge clk_i);
    endtask : wait_await

    // Frame k stored in sub-buffer s: status word, then payload words
    task automatic check_sub(input int k, input int s);
        mfr_pkg::status_word_t sw;
        logic [31:0]           w, m;
        logic                  sh;
        int                    i;
        sh = f_n[k] < f_len[k];
        sw = '0;
        sw.byte_count = 8'(f_n[k]);
        {sw.integrity, sw.protocol, sw.collision} = f_err[k] | {1'b0, sh, 1'b0};
        sw.combined_error_flag = (|f_err[k]) | sh;
        sw.length_error_flag = (f_len[k] > mfr_pkg::PAYLOAD_LIMIT) | sh;
        apb_read(12'(32'h11C + 32 * s), sw);
        for (int j = 0; j < 7; j++) begin
            for (int b = 0; b < 4; b++) begin
                i = 4 * j + b;
                w[8*b +: 8] = (i == 0) ? f_len[k] : 8'(k * 32 + i) ^ 8'hA5;
                m[8*b +: 8] = (i < f_n[k]) ? 8'hFF : 8'h00;
            end
            if (m != 0 && f_len[k] <= mfr_pkg::PAYLOAD_LIMIT) begin
                apb_read(12'(32'h100 + 32 * s + 4 * j), w, m);
            end
        end
    endtask : check_sub

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        error_cnt = 0;
        total_checks = 0;
        cycle_cnt = 0;
        seed = 32'hF9C6398C;
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int r = 0; r < 4; r++) apb_read(12'(4 * r), 32'h0000_0000);
        apb_read(12'h010, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            f_len[k] = 8'(2 + $unsigned($random(seed)) % 27);
            f_n[k] = f_len[k];
            f_err[k] = '0;
        end
        f_len[1] = 8'h1C;
        f_n[1] = 28;
        f_len[2] = 8'h1D;
        f_n[2] = 29;
        f_n[3] = 1;
        f_err[4] = 3'b100;
        f_err[5] = 3'b010;
        f_err[6] = 3'b001;
        apb_xfer(1'b1, mfr_pkg::IRQ_MASK_OFS, 32'h0000_0007);
        apb_xfer(1'b1, mfr_pkg::CTRL_OFS, 32'h0000_0003);
        for (int k = 0; k < 8; k++) cards.send_frame(k, f_len[k], f_n[k], f_err[k], $unsigned($random(seed)) % 2);
        wait_await();
        check("await_send_o", 32'(await_send_o), 32'h0000_0001);
        apb_read(mfr_pkg::STATUS_OFS, 32'h0000_0038);
        for (int k = 0; k < 8; k++) check_sub(k, k);
        apb_read(mfr_pkg::IRQ_STAT_OFS, 32'h0000_0007);
        check("irq_o", 32'(irq_o), 32'h0000_0001);
        apb_xfer(1'b1, mfr_pkg::IRQ_STAT_OFS, 32'h0000_0007);
        apb_read(mfr_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        check("irq_o", 32'(irq_o), 32'h0000_0000);
        apb_xfer(1'b1, mfr_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        apb_xfer(1'b1, mfr_pkg::CTRL_OFS, 32'h0000_0002);
        apb_read(mfr_pkg::STATUS_OFS, 32'h0000_0010);
        cards.send_frame(7, f_len[7], f_n[7], f_err[7], 0);
        wait_await();
        apb_read(mfr_pkg::STATUS_OFS, 32'h0000_0031);
        apb_read(mfr_pkg::IRQ_STAT_OFS, 32'h0000_0003);
        check("irq_o", 32'(irq_o), 32'h0000_0000);
        check_sub(7, 0);
        apb_xfer(1'b1, mfr_pkg::CTRL_OFS, 32'h0000_0003);
        cards.send_frame(1, f_len[1], f_n[1], f_err[1], 1);
        cards.send_frame(2, f_len[2], f_n[2], f_err[2], 0);
        apb_xfer(1'b1, mfr_pkg::CTRL_OFS, 32'h0000_0005);
        apb_read(mfr_pkg::STATUS_OFS, 32'h0000_0002);
        check_sub(1, 0);
        check_sub(2, 1);
        // Oversize frame must leave the first cycle's payload in sub-buffer 1
        apb_read(12'h120, {24'h868784, f_len[1]});
        for (int j = 1; j < 7; j++) apb_read(12'(32'h120 + 4 * j), 32'hA5A5_A5A5 ^ {8'(35 + 4 * j), 8'(34 + 4 * j),
            8'(33 + 4 * j), 8'(32 + 4 * j)});
        repeat (2) @(posedge clk_i);
        report_and_stop();
    end
endmodule : multi_frame_rx_buffer_test

`default_nettype wire
